//--- design/lsic_regs.sv
`timescale 1ns/1ps
// Function
// - The extended DMA addressing enable of a socket follows bit 3 of its DMA slave configuration word.
// - I/O accesses whose address bits 31:4 equal the DMA base field select that socket's DMA registers.
// - Socket-number bits 1:0 choose the index window 00h-3Fh, 40h-7Fh, 80h-BFh or C0h-FFh.
// - Socket-number bit 2 clear places the index/data pair at base and base+1, set places it at base+2 and base+3.
// - The host writes an index to the index address, then the data access is routed to the indexed register.
// - Index bits 7:6 pick which socket's register set the data access reaches.
// - The subsystem ID lock resets to zero, is one chip-wide bit, and when set makes the subsystem IDs read-only.
// - A set pin-mapping lock blocks writes to the pin-mapping register pair.
// - A set master-prefetch disable stops CardBus masters prefetching from PCI memory.
// - In D3 with the card powered the card reset is driven unless the D3 auto-reset disable bit is set.
// - In non-PCI interrupt modes management interrupts go to the PCI pin when management enable is 0, else ISA.
module lsic_regs (
  input  wire logic                      MCLK,
  input  wire logic                      RSTN,
  input  wire lsic_pkg::lsic_cfg_req_type CFG_REQ,
  output      logic                      CFG_ACK,
  output      logic [31:0]               CFG_RDATA,
  input  wire lsic_pkg::lsic_io_req_type  IO_REQ,
  input  wire logic [31:0]               LEGACY_BASE,
  output      logic                      IO_ACK,
  output      logic [7:0]                IO_RDATA,
  output      lsic_pkg::lsic_idx_acc_type IDX_ACC,
  output      logic [1:0]                DMA_SEL,
  output      logic [1:0]                EXT_ADDR_EN,
  output      logic                      SSID_WR_LOCK,
  output      logic                      PINMAP_WR_LOCK,
  output      logic                      MASTER_PREFETCH_OFF,
  output      logic                      PCIWAY_INT_EN,
  input  wire logic [3:0]                PWR_STATE,
  input  wire logic [1:0]                CARD_POWERED,
  output      logic [1:0]                CARD_RESET,
  input  wire logic                      NON_PCI_INT_MODE,
  input  wire logic [1:0]                MGMT_EVENT,
  output      logic [1:0]                MGMT_TO_PCI,
  output      logic [1:0]                MGMT_TO_ISA
);
  import lsic_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be, input logic [31:0] mask);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & mask;
    be_merge = (old_v & ~m) | (new_v & m);
  endfunction : be_merge

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [31:0] dma_cfg_reg   [2];
  logic [31:0] sock_num_reg  [2];
  logic [31:0] misc_sock_reg [2];
  logic [31:0] misc_chip_reg;
  logic [7:0]  index_reg     [2];

  // ****************************************************************
  // Configuration decode
  // ****************************************************************
  wire         f_sel   = CFG_REQ.func;
  wire         cfg_wr  = CFG_REQ.valid & CFG_REQ.we;
  wire         hit_dma = CFG_REQ.offset == DMA_CFG_OFFSET;
  wire         hit_sn  = CFG_REQ.offset == SOCK_NUM_OFFSET;
  wire         hit_mc  = CFG_REQ.offset == MISC_ONE_OFFSET;
  wire [31:0]  chip_wmask = f_sel ? (MISC_CHIP_MASK & ~MISC_F0_MASK) : MISC_CHIP_MASK;
  wire [31:0]  misc_view  = (misc_sock_reg[f_sel] & ~MISC_CHIP_MASK) | misc_chip_reg;
  wire [31:0]  cfg_rd_mux = hit_dma ? dma_cfg_reg[f_sel] :
                            hit_sn  ? sock_num_reg[f_sel] :
                            hit_mc  ? misc_view : 32'h0000_0000;

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      dma_cfg_reg[0]   <= DMA_CFG_RESET;
      dma_cfg_reg[1]   <= DMA_CFG_RESET;
      sock_num_reg[0]  <= {29'h0000_0000, SOCK_A_RESET};
      sock_num_reg[1]  <= {29'h0000_0000, SOCK_B_RESET};
      misc_sock_reg[0] <= MISC_ONE_RESET;
      misc_sock_reg[1] <= MISC_ONE_RESET;
      misc_chip_reg    <= MISC_ONE_RESET;
      CFG_ACK          <= 1'b0;
      CFG_RDATA        <= 32'h0000_0000;
    end else begin
      CFG_ACK   <= CFG_REQ.valid;
      CFG_RDATA <= (CFG_REQ.valid && !CFG_REQ.we) ? cfg_rd_mux : 32'h0000_0000;
      if (cfg_wr && hit_dma) begin
        dma_cfg_reg[f_sel] <= be_merge(dma_cfg_reg[f_sel], CFG_REQ.wdata, CFG_REQ.be, 32'hFFFF_FFFF);
      end
      if (cfg_wr && hit_sn) begin
        sock_num_reg[f_sel] <= be_merge(sock_num_reg[f_sel], CFG_REQ.wdata, CFG_REQ.be, SOCK_NUM_MASK);
      end
      if (cfg_wr && hit_mc) begin
        misc_sock_reg[f_sel] <= be_merge(misc_sock_reg[f_sel], CFG_REQ.wdata, CFG_REQ.be,
                                         MISC_ONE_MASK & ~MISC_CHIP_MASK);
        misc_chip_reg        <= be_merge(misc_chip_reg, CFG_REQ.wdata, CFG_REQ.be, chip_wmask);
      end
    end
  end

  // ****************************************************************
  // Legacy I/O decode
  // ****************************************************************
  wire [31:0] io_off   = IO_REQ.addr - LEGACY_BASE;
  wire        io_pair  = io_off[1];
  wire        io_hit   = IO_REQ.valid && (io_off[31:2] == 30'h0000_0000);
  wire        io_data  = io_hit && io_off[0];
  wire        io_index = io_hit && !io_off[0];
  wire [7:0]  cur_idx  = index_reg[io_pair];
  wire [1:0]  idx_sock = cur_idx[IDX_SOCK_MSB:IDX_SOCK_LSB];
  wire [1:0]  sock_match;
  wire [1:0]  dma_match;

  for (genvar f = 0; f < 2; f++) begin : g_sock
    assign sock_match[f] = (sock_num_reg[f][SOCK_BANK_BIT] == io_pair) &&
                           (sock_num_reg[f][1:0] == idx_sock);
    assign dma_match[f]  = IO_REQ.valid &&
                           (IO_REQ.addr[31:DMA_BASE_LSB] == dma_cfg_reg[f][31:DMA_BASE_LSB]);
  end

  wire        route_ok = io_data && (sock_match != 2'b00);

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      index_reg[0] <= 8'h00;
      index_reg[1] <= 8'h00;
      IO_ACK       <= 1'b0;
      IO_RDATA     <= 8'h00;
      IDX_ACC      <= '0;
      DMA_SEL      <= 2'b00;
    end else begin
      if (io_index && IO_REQ.we) begin
        index_reg[io_pair] <= IO_REQ.wdata;
      end
      IO_ACK         <= io_index;
      IO_RDATA       <= (io_index && !IO_REQ.we) ? cur_idx : 8'h00;
      IDX_ACC.stb    <= route_ok;
      IDX_ACC.we     <= route_ok && IO_REQ.we;
      IDX_ACC.sock_b <= route_ok && sock_match[1] && !sock_match[0];
      IDX_ACC.offset <= route_ok ? cur_idx[5:0] : 6'h00;
      IDX_ACC.wdata  <= (route_ok && IO_REQ.we) ? IO_REQ.wdata : 8'h00;
      DMA_SEL        <= dma_match;
    end
  end

  // ****************************************************************
  // Control outputs
  // ****************************************************************
  wire [1:0] d3_reset;
  wire [1:0] mgmt_isa;
  for (genvar f = 0; f < 2; f++) begin : g_ctl
    assign d3_reset[f] = (PWR_STATE[2*f +: 2] == D3_STATE) && CARD_POWERED[f] &&
                         !misc_sock_reg[f][MISC_D3NR_BIT];
    assign mgmt_isa[f] = misc_sock_reg[f][MISC_MGMT_BIT];
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      EXT_ADDR_EN         <= 2'b00;
      SSID_WR_LOCK        <= 1'b0;
      PINMAP_WR_LOCK      <= 1'b0;
      MASTER_PREFETCH_OFF <= 1'b0;
      PCIWAY_INT_EN       <= 1'b0;
      CARD_RESET          <= 2'b00;
      MGMT_TO_PCI         <= 2'b00;
      MGMT_TO_ISA         <= 2'b00;
    end else begin
      EXT_ADDR_EN         <= {dma_cfg_reg[1][DMA_EXT_BIT], dma_cfg_reg[0][DMA_EXT_BIT]};
      SSID_WR_LOCK        <= misc_chip_reg[MISC_SSID_BIT];
      PINMAP_WR_LOCK      <= misc_chip_reg[MISC_PINLK_BIT];
      MASTER_PREFETCH_OFF <= misc_chip_reg[MISC_NOPF_BIT];
      PCIWAY_INT_EN       <= misc_chip_reg[MISC_PCIWAY_BIT];
      CARD_RESET          <= d3_reset;
      MGMT_TO_PCI         <= MGMT_EVENT & ~(mgmt_isa & {2{NON_PCI_INT_MODE}});
      MGMT_TO_ISA         <= MGMT_EVENT & mgmt_isa & {2{NON_PCI_INT_MODE}};
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_idx_write;
    IO_REQ.valid && IO_REQ.we && io_index;
  endsequence
  sequence s_data_access;
    IO_REQ.valid && io_data && (sock_match != 2'b00);
  endsequence

  property p_ext_follow;
    @(posedge MCLK) disable iff (!RSTN) 1'b1 |=> EXT_ADDR_EN[0] == $past(dma_cfg_reg[0][DMA_EXT_BIT]);
  endproperty
  a_ext_follow: assert property (p_ext_follow) else $error("ext addr enable mismatch");

  property p_dma_sel;
    @(posedge MCLK) disable iff (!RSTN)
      (IO_REQ.valid && IO_REQ.addr[31:DMA_BASE_LSB] == dma_cfg_reg[1][31:DMA_BASE_LSB]) |=> DMA_SEL[1];
  endproperty
  a_dma_sel: assert property (p_dma_sel) else $error("dma decode missed");

  property p_route;
    @(posedge MCLK) disable iff (!RSTN)
      s_idx_write ##[1:2] s_data_access |=> IDX_ACC.stb && IDX_ACC.offset == $past(cur_idx[5:0]);
  endproperty
  a_route: assert property (p_route) else $error("indexed data access not routed");

  property p_pair;
    @(posedge MCLK) disable iff (!RSTN)
      IDX_ACC.stb |-> sock_num_reg[IDX_ACC.sock_b][SOCK_BANK_BIT] == $past(io_pair);
  endproperty
  a_pair: assert property (p_pair) else $error("wrong io pair");

  property p_sock_pick;
    @(posedge MCLK) disable iff (!RSTN)
      IDX_ACC.stb |-> sock_num_reg[IDX_ACC.sock_b][1:0] == $past(idx_sock);
  endproperty
  a_sock_pick: assert property (p_sock_pick) else $error("index socket select mismatch");

  property p_ssid_lock;
    @(posedge MCLK) disable iff (!RSTN)
      (cfg_wr && hit_mc && CFG_REQ.be[0]) |-> ##2 SSID_WR_LOCK == $past(CFG_REQ.wdata[0], 2);
  endproperty
  a_ssid_lock: assert property (p_ssid_lock) else $error("ssid lock not shared");

  property p_pin_f1;
    @(posedge MCLK) disable iff (!RSTN)
      (cfg_wr && hit_mc && f_sel) |-> ##2 PINMAP_WR_LOCK == $past(PINMAP_WR_LOCK);
  endproperty
  a_pin_f1: assert property (p_pin_f1) else $error("pin lock written from function 1");

  property p_prefetch;
    @(posedge MCLK) disable iff (!RSTN) misc_chip_reg[MISC_NOPF_BIT] |=> MASTER_PREFETCH_OFF;
  endproperty
  a_prefetch: assert property (p_prefetch) else $error("prefetch disable not applied");

  property p_d3_reset;
    @(posedge MCLK) disable iff (!RSTN)
      (PWR_STATE[1:0] == D3_STATE && CARD_POWERED[0] && !misc_sock_reg[0][MISC_D3NR_BIT]) |=> CARD_RESET[0];
  endproperty
  a_d3_reset: assert property (p_d3_reset) else $error("card reset not driven in D3");

  property p_mgmt;
    @(posedge MCLK) disable iff (!RSTN)
      (MGMT_EVENT[0] && NON_PCI_INT_MODE) |=> (MGMT_TO_ISA[0] != MGMT_TO_PCI[0]);
  endproperty
  a_mgmt: assert property (p_mgmt) else $error("management interrupt misrouted");

  property p_reserved;
    @(posedge MCLK) disable iff (!RSTN)
      (CFG_REQ.valid && !CFG_REQ.we && hit_sn) |=> CFG_RDATA[31:3] == 29'h0000_0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero");

  property p_reset_sock;
    @(posedge MCLK) $rose(RSTN) |-> sock_num_reg[1][2:0] == SOCK_B_RESET;
  endproperty
  a_reset_sock: assert property (p_reset_sock) else $error("socket number reset wrong");

endmodule : lsic_regs

//--- inc/lsic_pkg.sv
package lsic_pkg;

  // ****************************************************************
  // Configuration space layout
  // ****************************************************************
  localparam logic [7:0]  DMA_CFG_OFFSET   = 8'h90;
  localparam logic [7:0]  SOCK_NUM_OFFSET  = 8'h94;
  localparam logic [7:0]  MISC_ONE_OFFSET  = 8'h98;

  localparam int          DMA_EXT_BIT      = 3;
  localparam int          DMA_BASE_LSB     = 4;
  localparam int          SOCK_BANK_BIT    = 2;
  localparam int          MISC_SSID_BIT    = 0;
  localparam int          MISC_MGMT_BIT    = 1;
  localparam int          MISC_PCIWAY_BIT  = 2;
  localparam int          MISC_PINLK_BIT   = 8;
  localparam int          MISC_NOPF_BIT    = 9;
  localparam int          MISC_D3NR_BIT    = 10;

  localparam logic [31:0] DMA_CFG_RESET    = 32'h0000_0000;
  localparam logic [2:0]  SOCK_A_RESET     = 3'h0;
  localparam logic [2:0]  SOCK_B_RESET     = 3'h1;
  localparam logic [31:0] SOCK_NUM_MASK    = 32'h0000_0007;
  localparam logic [31:0] MISC_ONE_MASK    = 32'h0000_0707;
  localparam logic [31:0] MISC_CHIP_MASK   = 32'h0000_0305;
  localparam logic [31:0] MISC_F0_MASK     = 32'h0000_0300;
  localparam logic [31:0] MISC_ONE_RESET   = 32'h0000_0000;

  // ****************************************************************
  // Legacy I/O pair layout and power state encoding
  // ****************************************************************
  localparam logic [1:0]  D3_STATE         = 2'h3;
  localparam int          IDX_SOCK_MSB     = 7;
  localparam int          IDX_SOCK_LSB     = 6;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic        valid;
    logic        we;
    logic        func;
    logic [7:0]  offset;
    logic [3:0]  be;
    logic [31:0] wdata;
  } lsic_cfg_req_type;

  typedef struct packed {
    logic        valid;
    logic        we;
    logic [31:0] addr;
    logic [7:0]  wdata;
  } lsic_io_req_type;

  typedef struct packed {
    logic        stb;
    logic        we;
    logic        sock_b;
    logic [5:0]  offset;
    logic [7:0]  wdata;
  } lsic_idx_acc_type;

endpackage : lsic_pkg

//--- verification/lsic_host_model.sv
`timescale 1ns/1ps
module lsic_host_model (
  input  wire logic                       mclk,
  input  wire logic                       cfg_ack,
  input  wire logic [31:0]                cfg_rdata,
  input  wire logic                       io_ack,
  input  wire logic [7:0]                 io_rdata,
  input  wire lsic_pkg::lsic_idx_acc_type io_idx,
  input  wire logic [1:0]                 dma_sel,
  output      lsic_pkg::lsic_cfg_req_type cfg_req,
  output      lsic_pkg::lsic_io_req_type  io_req
);
  import lsic_pkg::*;
  logic             ack_seen;
  logic [31:0]      rdata_seen;
  logic [7:0]       rdata8_seen;
  lsic_idx_acc_type idx_seen;
  logic [1:0]       dma_seen;

  initial begin
    cfg_req = '0;
    io_req  = '0;
  end

  // ****************************************************************
  // One-cycle requests, answer taken one cycle later
  // ****************************************************************
  task automatic cfg(input logic f, input logic w, input logic [7:0] off, input logic [31:0] d);
    @(negedge mclk);
    cfg_req = '{1'b1, w, f, off, 4'hF, d};
    @(negedge mclk);
    cfg_req.valid = 1'b0;
    cfg_req.wdata = ~d;
    ack_seen = cfg_ack;
    rdata_seen = cfg_rdata;
  endtask : cfg

  // Index first, data next: the caller orders them
  task automatic io(input logic w, input logic [31:0] a, input logic [7:0] d);
    @(negedge mclk);
    io_req = '{1'b1, w, a, d};
    @(negedge mclk);
    io_req.valid = 1'b0;
    io_req.wdata = ~d;
    ack_seen = io_ack;
    rdata8_seen = io_rdata;
    idx_seen = io_idx;
    dma_seen = dma_sel;
  endtask : io
endmodule : lsic_host_model

//--- verification/tb_legacy_socket_io_config.sv
`timescale 1ns/1ps
module tb_legacy_socket_io_config;
  import lsic_pkg::*;
  logic             mclk = 1'b0;
  logic             rstn = 1'b0;
  lsic_cfg_req_type cfg_req;
  lsic_io_req_type  io_req;
  logic [31:0]      legacy_base = 32'h0000_03E0;
  logic [3:0]       pwr_state = 4'h0;
  logic [1:0]       card_powered = 2'h0;
  logic             non_pci = 1'b0;
  logic [1:0]       mgmt_event = 2'h0;
  logic             cfg_ack, io_ack, ssid, pinlk, nopf, pciway;
  logic [31:0]      cfg_rdata;
  logic [7:0]       io_rdata;
  lsic_idx_acc_type idx;
  logic [1:0]       dma_sel, ext_en, card_rst, to_pci, to_isa;
  int               bad_count = 0;
  int               comparisons = 0;

  always #25 mclk = ~mclk;

  lsic_regs dut (.MCLK(mclk), .RSTN(rstn), .CFG_REQ(cfg_req), .CFG_ACK(cfg_ack), .CFG_RDATA(cfg_rdata),
    .IO_REQ(io_req), .LEGACY_BASE(legacy_base), .IO_ACK(io_ack), .IO_RDATA(io_rdata), .IDX_ACC(idx),
    .DMA_SEL(dma_sel), .EXT_ADDR_EN(ext_en), .SSID_WR_LOCK(ssid), .PINMAP_WR_LOCK(pinlk),
    .MASTER_PREFETCH_OFF(nopf), .PCIWAY_INT_EN(pciway), .PWR_STATE(pwr_state), .CARD_POWERED(card_powered),
    .CARD_RESET(card_rst), .NON_PCI_INT_MODE(non_pci), .MGMT_EVENT(mgmt_event), .MGMT_TO_PCI(to_pci),
    .MGMT_TO_ISA(to_isa));

  lsic_host_model host (.mclk(mclk), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .io_ack(io_ack),
    .io_rdata(io_rdata), .io_idx(idx), .dma_sel(dma_sel), .cfg_req(cfg_req), .io_req(io_req));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic rd(input logic f, input logic [7:0] off, input logic [31:0] exp);
    host.cfg(f, 1'b0, off, 32'h0);
    check({31'h0, host.ack_seen}, 32'h1, "config ack");
    check(host.rdata_seen, exp, "config read");
  endtask : rd

  // Extra cycle lets the registered control outputs follow the write
  task automatic wr(input logic f, input logic [7:0] off, input logic [31:0] d);
    host.cfg(f, 1'b1, off, d);
    @(negedge mclk);
  endtask : wr

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  initial begin
    #200us;
    bad_count++;
    test_done;
  end

  initial begin
    repeat (12) @(negedge mclk);
    rstn = 1'b1;
    rd(1'b0, SOCK_NUM_OFFSET, 32'h0);
    rd(1'b1, SOCK_NUM_OFFSET, 32'h1);
    rd(1'b0, MISC_ONE_OFFSET, 32'h0);
    check({31'h0, ssid}, 32'h0, "lock after reset");
    $display("test reset values done");
    wr(1'b0, SOCK_NUM_OFFSET, 32'hFFFF_FFFF);
    rd(1'b0, SOCK_NUM_OFFSET, 32'h7);
    wr(1'b0, MISC_ONE_OFFSET, 32'hFFFF_FFFF);
    rd(1'b0, MISC_ONE_OFFSET, 32'h707);
    check({ssid, pinlk, nopf, pciway}, 32'hF, "chip controls set");
    rd(1'b1, MISC_ONE_OFFSET, 32'h305);
    wr(1'b1, MISC_ONE_OFFSET, 32'h0);
    rd(1'b0, MISC_ONE_OFFSET, 32'h702);
    check({ssid, pinlk, nopf}, 32'h3, "chip controls after func1 clear");
    wr(1'b0, MISC_ONE_OFFSET, 32'h0);
    check({pinlk, nopf}, 32'h0, "chip controls cleared");
    wr(1'b0, SOCK_NUM_OFFSET, 32'h0);
    $display("test register fields done");
    wr(1'b0, DMA_CFG_OFFSET, 32'h0000_1238);
    check(ext_en, 32'h1, "extended addressing on");
    host.io(1'b0, 32'h0000_1235, 8'h00);
    check(host.dma_seen, 32'h1, "dma base hit");
    host.io(1'b0, 32'h0000_1245, 8'h00);
    check(host.dma_seen, 32'h0, "dma base miss");
    wr(1'b0, DMA_CFG_OFFSET, 32'h0);
    check(ext_en, 32'h0, "extended addressing off");
    wr(1'b1, DMA_CFG_OFFSET, 32'h0000_2008);
    check(ext_en, 32'h2, "socket b extended addressing on");
    host.io(1'b0, 32'h0000_2003, 8'h00);
    check(host.dma_seen, 32'h2, "socket b dma base hit");
    $display("test dma config done");
    for (int k = 0; k < 4; k++) begin
      wr(1'b1, SOCK_NUM_OFFSET, 32'(k));
      host.io(1'b1, 32'h3E0, {k[1:0], 6'h05});
      check({31'h0, host.ack_seen}, 32'h1, "index ack");
      host.io(1'b1, 32'h3E1, 8'hA5);
      check(host.idx_seen, {1'b1, 1'b1, k != 0, 6'h05, 8'hA5}, "routed write");
    end
    host.io(1'b1, 32'h3E0, 8'h8C);
    host.io(1'b0, 32'h3E0, 8'h00);
    check(host.rdata8_seen, 32'h8C, "index readback");
    host.io(1'b0, 32'h3E1, 8'h00);
    check({31'h0, host.idx_seen.stb}, 32'h0, "unclaimed window");
    wr(1'b0, SOCK_NUM_OFFSET, 32'h4);
    wr(1'b1, SOCK_NUM_OFFSET, 32'h5);
    host.io(1'b1, 32'h3E0, 8'h41);
    host.io(1'b0, 32'h3E1, 8'h00);
    check({31'h0, host.idx_seen.stb}, 32'h0, "old pair silent");
    host.io(1'b1, 32'h3E2, 8'h41);
    check({31'h0, host.ack_seen}, 32'h1, "upper index ack");
    host.io(1'b0, 32'h3E3, 8'h00);
    check(host.idx_seen[16:8], {1'b1, 1'b0, 1'b1, 6'h01}, "upper pair read");
    wr(1'b0, SOCK_NUM_OFFSET, 32'h0);
    wr(1'b1, SOCK_NUM_OFFSET, 32'h1);
    $display("test legacy pair done");
    pwr_state = 4'h3;
    card_powered = 2'h3;
    repeat (2) @(negedge mclk);
    check(card_rst, 32'h1, "d3 card reset");
    wr(1'b0, MISC_ONE_OFFSET, 32'h400);
    check(card_rst, 32'h0, "d3 reset disabled");
    non_pci = 1'b1;
    mgmt_event = 2'h3;
    wr(1'b0, MISC_ONE_OFFSET, 32'h2);
    check({to_isa, to_pci}, 32'h6, "management steering");
    $display("test power and interrupts done");
    test_done;
  end
endmodule : tb_legacy_socket_io_config
